// file: packet_memory_bus_master_test.sv
`timescale 1ns/1ps
module packet_memory_bus_master_test;
  import pmem_pkg::*;

  logic        mclk, reset_n, reg_wr, reg_rd, wr_word_taken, rd_word_valid, take_q, req_q;
  logic        async_mode, word16, parity_even, hold_off, preempt;
  logic [7:0]  reg_addr, peek_index;
  logic [31:0] reg_wdata, reg_rdata, wr_word, rd_word, peek_data, rv;
  logic [5:0]  mode;
  logic [15:0] mr;
  logic [23:0] mad;
  int          bad_count, checked, tk, nreq;

  pmem_if w_if ();
  pmem_bus_master #(.IS_WRITER(1'b1)) pmem_bus_master_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wr_word(wr_word),
    .wr_word_taken(wr_word_taken), .rd_word(rd_word), .rd_word_valid(rd_word_valid), .pm(w_if));
  pmem_far_end pmem_far_end_i (.mclk(mclk), .reset_n(reset_n), .async_mode(async_mode), .word16(word16),
    .parity_even(parity_even), .hold_off(hold_off), .preempt(preempt), .peek_index(peek_index),
    .peek_data(peek_data), .pm(w_if));
  pmem_link_checker pmem_link_checker_i (.mclk(mclk), .reset_n(reset_n), .bus_request(w_if.bus_request),
    .bus_grant(w_if.bus_grant), .low_addr_select(w_if.low_addr_select), .cycle_active_n(w_if.cycle_active_n),
    .transfer_ready_n(w_if.transfer_ready_n), .pkt_addr_bus_out(w_if.pkt_addr_bus_out),
    .pkt_addr_bus_oe(w_if.pkt_addr_bus_oe), .dev_data_out(w_if.dev_data_out), .dev_data_oe(w_if.dev_data_oe));

  // Word pattern handed to the writer
  function automatic logic [31:0] pat(input int k);
    return k * 32'h0103070F + 32'h89ABCDEF;
  endfunction : pat

  // Byte parity expected for the current mode
  function automatic logic [31:0] par(input logic [31:0] d);
    logic [3:0] p;
    for (int i = 0; i < 4; i++) p[i] = ^d[i*8 +: 8] ^ ~mode[1];
    if (mode[3]) p[3:2] = 2'b00;
    return {28'h0000000, p};
  endfunction : par

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask : rd

  // One transfer job: program, start, optional stall or preemption, then verify
  task automatic run(input logic [5:0] m, input logic [23:0] s, input int n, input logic pre, input logic hold);
    int          i;
    int          k0;
    logic [23:0] ea;
    logic [31:0] e;
    mode = m;
    k0   = tk;
    ea   = s + (m[3] ? 24'h000002 : 24'h000004) * n;
    mad         <= s;
    nreq        <= 0;
    hold_off    <= hold;
    async_mode  <= m[0];
    word16      <= m[3];
    parity_even <= m[1];
    wr(REG_MODE, {26'h0000000, m});
    wr(REG_START, {8'h00, s});
    wr(REG_COUNT, n);
    wr(REG_CTRL, 32'h00000001);
    if (hold) begin
      repeat (8) @(posedge mclk);
      hold_off <= 1'b0;
    end
    if (pre) begin
      for (i = 0; i < 400 && w_if.cycle_active_n; i++) @(posedge mclk);
      repeat (2) @(posedge mclk);
      preempt <= 1'b1;
      repeat (3) @(posedge mclk);
      preempt <= 1'b0;
    end
    i = 0;
    do begin
      rd(REG_STATUS, rv);
      i++;
    end while (rv[0] !== 1'b0 && i < 2000);
    chk(rv, 32'h00000000);
    rd(REG_CURADR, rv);
    chk(rv, {8'h00, ea});
    repeat (4) @(posedge mclk);
    for (i = 0; i < n; i++) begin
      peek_index <= 8'(m[3] ? (s >> 1) + i : (s >> 2) + i);
      @(posedge mclk);
      @(negedge mclk);
      e = pat(k0 + i);
      if (m[3]) e[31:16] = 16'h0000;
      chk(m[3] ? {16'h0000, peek_data[15:0]} : peek_data, e);
      @(posedge mclk);
    end
    $display("test done mode=%h start=%h words=%0d", m, s, n);
  endtask : run

  task end_sim;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Interface watch in mid-cycle, where every level has settled
  always @(negedge mclk) begin
    take_q <= wr_word_taken;
    req_q  <= w_if.bus_request;
    if (w_if.bus_request && !req_q) nreq <= nreq + 1;
    if (!w_if.cycle_active_n && w_if.bus_grant && !w_if.transfer_ready_n) begin
      chk({28'h0000000, w_if.pkt_data_bus[35:32]}, par(w_if.pkt_data_bus[31:0]));
      if (!mode[0]) begin
        chk({16'h0000, w_if.pkt_addr_bus_out}, {16'h0000, mad[15:0]});
        chk({31'h0, w_if.addr_match_flag}, {31'h0, (mad[13:2] == mr[11:0]) && ((mad[17:14] & ~mr[15:12]) == 4'h0)});
        mad <= mad + (mode[3] ? 24'h000002 : 24'h000004);
      end
    end
    if (!mode[0] && !w_if.cycle_active_n && !w_if.low_addr_select)
      chk({16'h0, w_if.pkt_addr_bus_out}, {16'h0, mode[5] ? {mad[23:9], mad[mode[3] ? 1 : 2]} : mad[23:8]});
    if (mode[4] && w_if.bus_request && !w_if.bus_grant && w_if.low_addr_select)
      chk(w_if.pkt_data_bus[31:0], {8'h00, mad});
  end

  // Next word after each one the writer takes
  always @(posedge mclk) begin
    if (take_q) begin
      tk      <= tk + 1;
      wr_word <= pat(tk + 1);
    end
  end

  // Watchdog
  initial begin
    #1200000;
    bad_count++;
    $display("watchdog expired");
    end_sim;
  end

  // Main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, take_q, req_q, async_mode, word16, parity_even, hold_off, preempt} = '0;
    reg_addr = 8'h00;
    peek_index = 8'h00;
    reg_wdata = 32'h00000000;
    mode = 6'h00;
    mr = 16'h0000;
    mad = 24'h000000;
    {bad_count, checked, tk, nreq} = '0;
    wr_word = pat(0);
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk({28'h0, w_if.bus_request, w_if.cycle_active_n, w_if.pkt_addr_bus_oe, w_if.dev_data_oe}, 32'h00000004);
    @(posedge mclk);
    rd(REG_MODE, rv);
    chk(rv, 32'h00000000);
    wr(REG_MATCH, 32'h00000042);
    mr = 16'h0042;
    rd(REG_MATCH, rv);
    chk(rv, 32'h00000042);
    rd(8'h20, rv);
    chk(rv, 32'h00000000);
    $display("test done registers");
    run(6'h10, 24'h000100, 4, 1'b0, 1'b1);
    run(6'h02, 24'h000140, 6, 1'b1, 1'b0);
    run(6'h20, 24'h00FFF8, 4, 1'b0, 1'b0);
    chk(nreq, 32'h00000002);
    run(6'h01, 24'h000200, 3, 1'b0, 1'b0);
    run(6'h03, 24'h000240, 3, 1'b1, 1'b0);
    run(6'h0A, 24'h000300, 3, 1'b0, 1'b0);
    chk(rd_word | {31'h0, rd_word_valid}, 32'h00000000);
    end_sim;
  end
endmodule : packet_memory_bus_master_test

// file: pmem_bus_master.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module pmem_bus_master
  import pmem_pkg::*;
#(
  parameter bit IS_WRITER = 1'b1,
  parameter int CNT_W     = 16
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Register port
  input  wire logic [pmem_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [pmem_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [pmem_pkg::REG_DW-1:0] reg_rdata,
  // Word stream
  input  wire logic [pmem_pkg::WORD_W-1:0] wr_word,
  output logic                       wr_word_taken,
  output logic      [pmem_pkg::WORD_W-1:0] rd_word,
  output logic                       rd_word_valid,
  // Packet memory port
  pmem_if.device                     pm
);
  import pmem_pkg::*;

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [MODE_W-1:0]  mode;
  logic [REG_DW/2-1:0] match_val;
  logic [PADDR_W-1:0] start_addr;
  logic [CNT_W-1:0]   word_count;
  logic [PADDR_W-1:0] addr;
  logic [CNT_W-1:0]   words_left;
  logic               parity_err;
  logic               word_loaded;
  logic [PD_W-1:0]    out_word;
  dev_state_e         state;
  logic               rdy_meta, rdy_sync, gnt_meta, gnt_sync;

  logic               async_m, word16, go;
  logic               rdy_seen, gnt_seen, complete, lost, roll;
  logic [PADDR_W-1:0] next_addr;
  logic [PAR_W-1:0]   exp_par, wr_par;
  logic [MATCH_UP_W-1:0] up_ok;

  assign async_m  = mode[M_ASYNC];
  assign word16   = mode[M_WORD16];
  assign go       = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO]
                    && (state == ST_IDLE) && (word_count != '0);

  // Input synchronisers, second stage feeds logic
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
      gnt_meta <= 1'b0;
      gnt_sync <= 1'b0;
    end else begin
      rdy_meta <= ~pm.transfer_ready_n;
      rdy_sync <= rdy_meta;
      gnt_meta <= pm.bus_grant;
      gnt_sync <= gnt_meta;
    end
  end

  assign rdy_seen  = async_m ? rdy_sync : ~pm.transfer_ready_n;
  assign gnt_seen  = async_m ? gnt_sync : pm.bus_grant;
  assign next_addr = addr + (word16 ? STEP16 : STEP32);
  assign roll      = next_addr[PADDR_W-1:ROLL_LSB] != addr[PADDR_W-1:ROLL_LSB];
  assign lost      = (state == ST_XFER) && !gnt_seen;
  assign complete  = (state == ST_XFER) && gnt_seen && rdy_seen;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode       <= MODE_RESET;
      match_val  <= '0;
      start_addr <= '0;
      word_count <= '0;
    end else if (reg_wr) begin
      if (reg_addr == REG_MODE)  mode       <= reg_wdata[MODE_W-1:0];
      if (reg_addr == REG_MATCH) match_val  <= reg_wdata[REG_DW/2-1:0];
      if (reg_addr == REG_START) start_addr <= reg_wdata[PADDR_W-1:0];
      if (reg_addr == REG_COUNT) word_count <= reg_wdata[CNT_W-1:0];
    end
  end

  // Register reads, data one cycle after strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_MODE:   reg_rdata <= REG_DW'(mode);
        REG_MATCH:  reg_rdata <= REG_DW'(match_val);
        REG_START:  reg_rdata <= REG_DW'(start_addr);
        REG_COUNT:  reg_rdata <= REG_DW'(word_count);
        REG_STATUS: reg_rdata <= REG_DW'({parity_err, state != ST_IDLE});
        REG_CURADR: reg_rdata <= REG_DW'(addr);
        default:    reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  // reset idles the port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:    if (go) state <= ST_REQ;
        ST_REQ:     if (gnt_seen) state <= ST_XFER;
        ST_XFER: begin
          if (lost) begin
            state <= ST_RELEASE;
          end else if (complete && (async_m || roll || words_left == CNT_W'(1))) begin
            state <= ST_RELEASE;
          end
        end
        // wait for grant and ready idle
        ST_RELEASE: begin
          if (!gnt_seen && !rdy_seen) begin
            state <= (words_left != '0) ? ST_REQ : ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr       <= '0;
      words_left <= '0;
    end else if (go) begin
      addr       <= start_addr;
      words_left <= word_count;
    end else if (complete) begin
      addr       <= next_addr;
      words_left <= words_left - CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Write data path
  // ---------------------------------------------------------------
  // writer fetches next word when needed
  // In sync mode, except at a 64K roll or the last word, the next word is taken on the edge that completes one, so it stands for the next ready
  assign wr_word_taken = IS_WRITER
                         && (((state == ST_REQ) && gnt_seen && !word_loaded)
                         || (complete && !async_m && !roll && words_left != CNT_W'(1)));

  // parity per byte with selected sense
  assign wr_par = byte_parity(word16 ? {16'h0000, wr_word[HALF_W-1:0]} : wr_word, mode[M_PAR_EVEN]);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_word    <= '0;
      word_loaded <= 1'b0;
    end else if (complete && !wr_word_taken) begin
      word_loaded <= 1'b0;
    end else if (wr_word_taken) begin
      word_loaded <= 1'b1;
      // 16-bit path uses low half only
      if (word16) begin
        out_word <= {2'b00, wr_par[1:0], 16'h0000, wr_word[HALF_W-1:0]};
      end else begin
        out_word <= {wr_par, wr_word};
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  assign exp_par = byte_parity(pm.pkt_data_bus[WORD_W-1:0], mode[M_PAR_EVEN]);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_word       <= '0;
      rd_word_valid <= 1'b0;
    end else begin
      rd_word_valid <= !IS_WRITER && complete;
      if (!IS_WRITER && complete) begin
        rd_word <= word16 ? {16'h0000, pm.pkt_data_bus[HALF_W-1:0]} : pm.pkt_data_bus[WORD_W-1:0];
      end
    end
  end

  // sticky check error, set beats clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      parity_err <= 1'b0;
    end else if (!IS_WRITER && complete && mode[M_PAR_CHECK]
                 && ((word16 ? {2'b00, exp_par[1:0] ^ pm.pkt_data_bus[PAR_LSB +: 2]}
                             : exp_par ^ pm.pkt_data_bus[PAR_LSB +: PAR_W]) != '0)) begin
      parity_err <= 1'b1;
    end else if (reg_wr && (reg_addr == REG_STATUS) && reg_wdata[STAT_PARERR]) begin
      parity_err <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // request only in request state
  assign pm.bus_request    = (state == ST_REQ);
  assign pm.cycle_active_n = (state != ST_XFER);
  assign pm.pkt_addr_bus_oe = (state == ST_XFER);

  // interleave bank bit on line 0
  always_comb begin
    if (pm.low_addr_select) begin
      pm.pkt_addr_bus_out = addr[PA_W-1:0];
    end else if (mode[M_INTERLEAVE]) begin
      pm.pkt_addr_bus_out = {addr[PADDR_W-1:9], word16 ? addr[1] : addr[2]};
    end else begin
      pm.pkt_addr_bus_out = addr[PADDR_W-1:8];
    end
  end

  assign pm.dev_data_oe  = ((state == ST_REQ) && mode[M_ADDR_ON_DATA] && pm.low_addr_select)
                           || (IS_WRITER && (state == ST_XFER));
  assign pm.dev_data_out = (state == ST_REQ) ? PD_W'(addr) : out_word;

  // match compare with gated upper bits
  for (genvar i = 0; i < MATCH_UP_W; i++) begin : g_up
    assign up_ok[i] = match_val[MATCH_LOW_W+i] || !addr[CMP_UP_LSB+i];
  end
  assign pm.addr_match_flag = (addr[CMP_ADR_LSB +: MATCH_LOW_W] == match_val[MATCH_LOW_W-1:0])
                              && (&up_ok);

endmodule : pmem_bus_master

// file: pmem_far_end.sv
`timescale 1ns/1ps
module pmem_far_end
  import pmem_pkg::*;
#(
  parameter int DEPTH_W     = 8,
  parameter int WAIT_CYCLES = 2
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  // Control
  input  wire logic                 async_mode,
  input  wire logic                 word16,
  input  wire logic                 parity_even,
  input  wire logic                 hold_off,
  input  wire logic                 preempt,
  // Memory inspection
  input  wire logic [DEPTH_W-1:0]   peek_index,
  output logic      [pmem_pkg::WORD_W-1:0] peek_data,
  // Packet memory port
  pmem_if.memside                   pm
);
  import pmem_pkg::*;

  localparam int CW = $clog2(WAIT_CYCLES + 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [WORD_W-1:0]  mem [2**DEPTH_W];
  far_state_e         state;
  logic [CW-1:0]      wait_cnt;
  logic [DEPTH_W-1:0] idx;
  logic               ready;

  assign idx = word16 ? pm.pkt_addr_bus_out[DEPTH_W:1] : pm.pkt_addr_bus_out[DEPTH_W+1:2];
  assign pm.transfer_ready_n = ~ready;
  // Low select also held 0 while grant is held off, so a floating request is seen
  assign pm.low_addr_select  = (state != F_GRANT) && !((state == F_IDLE) && hold_off);
  assign pm.mem_data_oe      = (state == F_XFER) && !pm.dev_data_oe;

  // grant held through access or until preempt, then dropped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state        <= F_IDLE;
      pm.bus_grant <= 1'b0;
      ready        <= 1'b0;
      wait_cnt     <= '0;
    end else begin
      unique case (state)
        F_IDLE: begin
          if (pm.bus_request && !hold_off) begin
            state        <= F_GRANT;
            pm.bus_grant <= 1'b1;
          end
        end
        F_GRANT: begin
          if (!pm.cycle_active_n) begin
            state    <= F_XFER;
            wait_cnt <= CW'(WAIT_CYCLES);
          end
        end
        F_XFER: begin
          if (pm.cycle_active_n) begin
            state        <= F_CLOSE;
            ready        <= 1'b0;
            pm.bus_grant <= 1'b0;
          end else begin
            if (preempt) pm.bus_grant <= 1'b0;
            if (wait_cnt != '0) begin
              wait_cnt <= wait_cnt - CW'(1);
              if (!async_mode) ready <= 1'b0;
            // ready for store or valid data
            end else if (!ready || !async_mode) begin
              ready    <= 1'b1;
              wait_cnt <= async_mode ? '0 : CW'(WAIT_CYCLES);
            end
          end
        end
        // Request may already be back after a preemption, so never wait on it
        F_CLOSE: begin
          state <= F_IDLE;
        end
      endcase
    end
  end

  // Store written words on ready
  always_ff @(posedge mclk) begin
    if ((state == F_XFER) && ready && pm.dev_data_oe && !pm.cycle_active_n) begin
      mem[idx] <= word16 ? {16'h0000, pm.pkt_data_bus[HALF_W-1:0]} : pm.pkt_data_bus[WORD_W-1:0];
    end
  end

  // Read data with generated parity
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pm.mem_data_out <= '0;
      peek_data       <= '0;
    end else begin
      pm.mem_data_out <= {byte_parity(mem[idx], parity_even), mem[idx]};
      peek_data       <= mem[peek_index];
    end
  end

endmodule : pmem_far_end

// file: pmem_if.sv
`timescale 1ns/1ps
interface pmem_if;
  import pmem_pkg::*;

  logic                bus_request;
  logic                bus_grant;
  logic                low_addr_select;
  logic                cycle_active_n;
  logic                transfer_ready_n;
  logic                addr_match_flag;
  logic [PA_W-1:0]     pkt_addr_bus_out;
  logic                pkt_addr_bus_oe;
  logic [PD_W-1:0]     dev_data_out;
  logic                dev_data_oe;
  logic [PD_W-1:0]     mem_data_out;
  logic                mem_data_oe;
  logic [PD_W-1:0]     pkt_data_bus;

  // Resolved data bus level; undriven reads as zero
  assign pkt_data_bus = dev_data_oe ? dev_data_out : (mem_data_oe ? mem_data_out : '0);

  modport device (
    input  bus_grant, low_addr_select, transfer_ready_n, pkt_data_bus,
    output bus_request, cycle_active_n, pkt_addr_bus_out, pkt_addr_bus_oe,
    output dev_data_out, dev_data_oe, addr_match_flag
  );

  modport memside (
    input  bus_request, cycle_active_n, pkt_addr_bus_out, pkt_addr_bus_oe,
    input  pkt_data_bus, dev_data_oe, addr_match_flag,
    output bus_grant, low_addr_select, transfer_ready_n, mem_data_out, mem_data_oe
  );
endinterface : pmem_if

// file: pmem_link_asserts.sv
`timescale 1ns/1ps
module pmem_link_checker (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       reset_n,
  // Handshake
  input wire logic                       bus_request,
  input wire logic                       bus_grant,
  input wire logic                       low_addr_select,
  input wire logic                       cycle_active_n,
  input wire logic                       transfer_ready_n,
  // Buses
  input wire logic [pmem_pkg::PA_W-1:0]  pkt_addr_bus_out,
  input wire logic                       pkt_addr_bus_oe,
  input wire logic [pmem_pkg::PD_W-1:0]  dev_data_out,
  input wire logic                       dev_data_oe
);
  import pmem_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Asking for the bus, and the cycle grant is seen
  sequence s_asking;
    bus_request && !bus_grant;
  endsequence
  sequence s_granted;
    bus_request && bus_grant;
  endsequence

  chk_req_release: assert property (s_granted |-> ##[1:4] !bus_request)
    else $error("request still high after grant");
  chk_strobe_start: assert property ($fell(bus_request) |-> !cycle_active_n)
    else $error("strobe not active when request fell");
  chk_strobe_no_req: assert property (!cycle_active_n |-> !bus_request)
    else $error("request high during strobe");
  chk_addr_drive: assert property (pkt_addr_bus_oe == !cycle_active_n)
    else $error("address drive differs from strobe");
  chk_strobe_granted: assert property ($fell(cycle_active_n) |-> $past(bus_grant))
    else $error("strobe without grant");
  chk_preempt_end: assert property (!bus_grant && !cycle_active_n |-> ##[1:4] cycle_active_n)
    else $error("strobe kept after grant loss");
  chk_addr_hold: assert property (!cycle_active_n && !$past(cycle_active_n) && $past(transfer_ready_n)
    && $stable(low_addr_select) |-> $stable(pkt_addr_bus_out))
    else $error("address moved without ready");
  chk_bus_release: assert property ($rose(cycle_active_n) |-> !dev_data_oe && !pkt_addr_bus_oe)
    else $error("buses driven after strobe end");
  chk_req_float: assert property (s_asking ##0 !low_addr_select |-> !dev_data_oe)
    else $error("data driven while low select is 0");
  chk_req_addr: assert property (s_asking ##0 (low_addr_select && dev_data_oe) |-> dev_data_out[31:24] == 8'h00)
    else $error("request address not zero extended");
endmodule : pmem_link_checker

// file: pmem_pkg.sv
package pmem_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PADDR_W = 24;   // Packet byte address
  localparam int PA_W    = 16;   // Address pins
  localparam int PD_W    = 36;   // Data pins incl. parity
  localparam int WORD_W  = 32;
  localparam int HALF_W  = 16;
  localparam int PAR_W   = 4;
  localparam int PAR_LSB = 32;   // Parity lines 35:32
  localparam int REG_AW  = 8;
  localparam int REG_DW  = 32;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [REG_AW-1:0] REG_MODE   = 8'h00;
  localparam logic [REG_AW-1:0] REG_MATCH  = 8'h04;  // address_boundary_compare
  localparam logic [REG_AW-1:0] REG_START  = 8'h08;
  localparam logic [REG_AW-1:0] REG_COUNT  = 8'h0C;
  localparam logic [REG_AW-1:0] REG_CTRL   = 8'h10;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h14;
  localparam logic [REG_AW-1:0] REG_CURADR = 8'h18;

  // Mode register fields
  localparam int MODE_W            = 6;
  localparam int M_ASYNC           = 0;  // async_select
  localparam int M_PAR_EVEN        = 1;  // parity sense
  localparam int M_PAR_CHECK       = 2;  // parity_check_enable
  localparam int M_WORD16          = 3;  // word_width_select
  localparam int M_ADDR_ON_DATA    = 4;  // addr_on_data_enable
  localparam int M_INTERLEAVE      = 5;  // interleave_select
  localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;

  // Control and status fields
  localparam int CTRL_GO     = 0;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_PARERR = 1;

  // Match register layout
  localparam int MATCH_LOW_W = 12;
  localparam int MATCH_UP_W  = 4;
  localparam int CMP_ADR_LSB = 2;   // Address bits 13:2 against match 11:0
  localparam int CMP_UP_LSB  = 14;  // Address bits 17:14 gated by match 15:12

  // Address steps
  localparam logic [PADDR_W-1:0] STEP32 = 24'h000004;
  localparam logic [PADDR_W-1:0] STEP16 = 24'h000002;
  localparam int ROLL_LSB = 16;     // 64K boundary

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_REQ     = 2'b01,
    ST_XFER    = 2'b10,
    ST_RELEASE = 2'b11
  } dev_state_e;

  typedef enum logic [1:0] {
    F_IDLE  = 2'b00,
    F_GRANT = 2'b01,
    F_XFER  = 2'b10,
    F_CLOSE = 2'b11
  } far_state_e;

  // Per-byte parity: odd when even_sel is 0, even when 1
  function automatic logic [PAR_W-1:0] byte_parity(input logic [WORD_W-1:0] d, input logic even_sel);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = (^d[i*8 +: 8]) ^ ~even_sel;
    end
    return p;
  endfunction : byte_parity

endpackage : pmem_pkg
